// *** include/svt_defines.vh ***
// constants for the sequence-voltage stage timer block
`ifndef SVT_DEFINES_VH
`define SVT_DEFINES_VH
// =====================================
// timing
`define SVT_CLK_HZ 20000000
`define SVT_TS_MS 1
`define SVT_MS_CYCLES (`SVT_CLK_HZ / 1000 * `SVT_TS_MS)
`define SVT_TICK_MS 5
`define SVT_PRETRIG_MS 20
`define SVT_PREFAULT_MS 200
`define SVT_PRETRIG_TICKS (`SVT_PRETRIG_MS / `SVT_TICK_MS)
`define SVT_PREFAULT_TICKS (`SVT_PREFAULT_MS / `SVT_TICK_MS)
`define SVT_REC_DEPTH 12
`define SVT_INV100 11'sd655
// =====================================
// word addresses
`define SVT_A_CTRL 10'h000
`define SVT_A_CFG 10'h010
`define SVT_A_STAT 10'h020
`define SVT_A_REC 2'b10
// =====================================
// field positions
`define SVT_CTRL_CLR 0
`define SVT_M_INV 0
`define SVT_M_UNDER 1
`define SVT_M_DLYREL 2
`define SVT_M_RSTREL 3
`define SVT_M_CONT 4
`define SVT_M_MASK 8
// =====================================
// reset values
`define SVT_FIX_MS 40
`define SVT_REL_MS 60
`define SVT_RST_MODE 16'h3F0C
// tick counts of the two defaults above, sized to their registers
`define SVT_RST_FIX 19'h00008
`define SVT_RST_REL 15'h0000C
`define SVT_RST_K 13'h0005
`define SVT_RST_EXP 12'h064
`endif

// *** rtl/svt_tick.v ***
// millisecond time stamp and 5 ms tick generator
`timescale 1ns/1ps
`include "svt_defines.vh"
module svt_tick #(
    parameter MS_CYCLES = `SVT_MS_CYCLES
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // ticks
    output wire tick_5ms,
    output wire [31:0] stamp_ms
);
reg [15:0] div_reg;
reg [2:0] sub_reg;
reg [31:0] ms_reg;
wire ms_end = (div_reg == MS_CYCLES - 1);
wire sub_end = (sub_reg == `SVT_TICK_MS - 1);
assign tick_5ms = ms_end & sub_end;
assign stamp_ms = ms_reg;
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        div_reg <= 16'h0000;
        sub_reg <= 3'h0;
        ms_reg <= 32'h0000_0000;
    end
    else
    begin
        div_reg <= ms_end ? 16'h0000 : div_reg + 16'h0001;
        if (ms_end)
        begin
            ms_reg <= ms_reg + 32'h0000_0001;
            sub_reg <= sub_end ? 3'h0 : sub_reg + 3'h1;
        end
    end
end
endmodule // svt_tick

// *** rtl/svt_inverse_delay_mode.v ***
// inverse-time rate term: ratio^exponent - 1, or 1 - ratio^exponent when under, floored at zero, in Q8.8
`timescale 1ns/1ps
`include "svt_defines.vh"
module svt_inv_rate (
    // ratio Q8.8, exponent in hundredths
    input wire [15:0] ratio,
    input wire [11:0] expo,
    input wire under,
    // rate term Q8.8
    output reg [15:0] rate
);
reg [3:0] msb;
reg [15:0] norm;
reg signed [13:0] lg;
reg signed [39:0] prod;
reg signed [23:0] e;
reg [15:0] base;
reg [15:0] pw;
integer n;
// log and antilog by straight-line segments; error stays within a few percent
always @*
begin
    msb = 4'h0;
    for (n = 0; n < 16; n = n + 1)
        if (ratio[n])
            msb = n[3:0];
    norm = ratio << (4'hF - msb);
    lg = $signed({2'b00, msb, norm[14:7]}) - 14'sh0800;
    prod = lg * $signed({1'b0, expo}) * `SVT_INV100;
    e = prod[39:16];
    base = {8'h01, e[7:0]};
    if (ratio == 16'h0000)
        pw = 16'h0000;
    else if (e >= 24'sh000800)
        pw = 16'hFFFF;
    else if (e < -24'sh000800)
        pw = 16'h0000;
    else if (!e[11])
        pw = base << e[10:8];
    else
        pw = base >> (4'h0 - e[11:8]);
    if (under)
        rate = (pw < 16'h0100) ? 16'h0100 - pw : 16'h0000;
    else
        rate = (pw > 16'h0100) ? pw - 16'h0100 : 16'h0000;
end
endmodule // svt_inv_rate

// *** rtl/svt_top.v ***
// four-stage sequence-voltage operate/release timer with events, counters and records
// Behaviour
// - zero delay trips together with start
// - fixed delay trips after set ticks
// - inverse time from dial over ratio power term
// - delay type selects fixed or inverse, fixed default
// - fixed delay in 5 ms steps, 40 ms
// - dial in 10 ms steps, 50 ms
// - exponent in hundredths, default 1.00
// - release time 5 ms steps, 60 ms
// - delayed release holds start until expiry, except after a trip, where start drops at once
// - operate counter cleared after release or drop
// - optional counting on through release
// - no trip while pick-up is dropped
// - four stages, six events each
// - event mask per event, time stamped
// - clearable start, trip, blocked counters
// - twelve newest records per stage, ring
// - record holds stamp, levels, remaining, group
// - blocking gives blocked, releases earlier start
// - drop-out hysteresis lives in comparator
`timescale 1ns/1ps
`include "svt_defines.vh"
module svt_top #(
    parameter MS_CYCLES = `SVT_MS_CYCLES
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // comparator and blocking matrix
    input wire [3:0] pickup,
    input wire [3:0] block_in,
    input wire [63:0] ratio_q88,
    input wire [15:0] measured_level,
    input wire [2:0] setting_group,
    // register port
    input wire [9:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    // stage outputs
    output wire [3:0] start_out,
    output wire [3:0] trip_out,
    output wire [3:0] blocked_out,
    output wire [23:0] event_pulse,
    output wire [31:0] event_stamp
);
// =====================================
// shared decode
function sel16;
    input [9:0] a;
    input [9:0] base;
    begin
        sel16 = (a[9:4] == base[9:4]);
    end
endfunction

wire tick_5ms;
wire [31:0] stamp_ms;
wire [127:0] rd_flat;
wire [23:0] ev_next_flat;
reg [31:0] rdata_reg;
reg [31:0] rd_sel;
reg [31:0] stamp_reg;
reg [15:0] hist_mem [0:63];
reg [5:0] hp_reg;
integer k;

svt_tick #(
    .MS_CYCLES(MS_CYCLES)
) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_5ms(tick_5ms),
    .stamp_ms(stamp_ms)
);

wire ctrl_hit = sel16(reg_addr, `SVT_A_CTRL) & (reg_addr[3:0] == 4'h0);
wire clr_cnt = reg_wr & ctrl_hit & reg_wdata[`SVT_CTRL_CLR];
// pointers must wrap in the ring; a wide index would run off the low end
wire [31:0] p20_full = {26'h0, hp_reg} - `SVT_PRETRIG_TICKS;
wire [31:0] p200_full = {26'h0, hp_reg} - `SVT_PREFAULT_TICKS;
wire [15:0] pre20 = hist_mem[p20_full[5:0]];
wire [15:0] pre200 = hist_mem[p200_full[5:0]];

// =====================================
// level history, one sample per tick
always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
        hp_reg <= 6'h00;
    else if (tick_5ms)
        hp_reg <= hp_reg + 6'h01;
end

// history holds data only, so no reset needed
always @(posedge clk_sys)
begin
    if (tick_5ms)
        hist_mem[hp_reg] <= measured_level;
end

// =====================================
// stages
genvar i;
generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_st
        reg [15:0] mode_reg;
        reg [18:0] fix_reg;
        reg [12:0] k_reg;
        reg [11:0] exp_reg;
        reg [14:0] rel_reg;
        reg start_reg, trip_reg, blk_reg, rls_reg;
        reg start_next, trip_next, rls_next;
        reg [18:0] op_reg, op_next;
        reg [23:0] acc_reg, acc_next;
        reg [14:0] rc_reg, rc_next;
        reg [15:0] cs_reg, ct_reg, cb_reg;
        reg [15:0] pf_reg;
        reg [5:0] ev_reg;
        reg [3:0] wp_reg;
        reg [31:0] rd_word;
        reg [31:0] rec_ts [0:11];
        reg [31:0] rec_lv [0:11];
        reg [31:0] rec_id [0:11];
        reg [31:0] rec_rm [0:11];
        wire [15:0] rate;
        wire pk = pickup[i] & ~block_in[i];
        wire blk_next = pickup[i] & block_in[i];
        wire inv_mode = mode_reg[`SVT_M_INV];
        wire [23:0] thr = {2'b00, k_reg, 9'h000};
        wire [23:0] rem = inv_mode ? ((acc_reg < thr) ? thr - acc_reg : 24'h000000)
            : ((op_reg < fix_reg) ? {5'h00, fix_reg - op_reg} : 24'h000000);
        wire [2:0] on_ev = {blk_next & ~blk_reg, trip_next & ~trip_reg, start_next & ~start_reg};
        wire [5:0] ev_next = {~blk_next & blk_reg, on_ev[2], ~trip_next & trip_reg, on_ev[1],
            ~start_next & start_reg, on_ev[0]} & mode_reg[`SVT_M_MASK +: 6];
        wire cfg_hit = sel16(reg_addr, `SVT_A_CFG) & (reg_addr[3:2] == i);
        wire stat_hit = sel16(reg_addr, `SVT_A_STAT) & (reg_addr[3:2] == i);
        wire rec_hit = (reg_addr[9:8] == `SVT_A_REC) & (reg_addr[7:6] == i) & (reg_addr[5:2] < `SVT_REC_DEPTH);

        svt_inv_rate u_inv_rate (
            .ratio(ratio_q88[i*16 +: 16]),
            .expo(exp_reg),
            .under(mode_reg[`SVT_M_UNDER]),
            .rate(rate)
        );

        // ---- operate and release timing
        always @*
        begin
            start_next = start_reg;
            trip_next = trip_reg;
            rls_next = rls_reg;
            op_next = op_reg;
            acc_next = acc_reg;
            rc_next = rc_reg;
            if (pk)
            begin
                rls_next = 1'b0;
                rc_next = 15'h0000;
                start_next = 1'b1;
                if (tick_5ms && !trip_reg)
                begin
                    op_next = op_reg + 19'h00001;
                    acc_next = acc_reg + {8'h00, rate};
                end
                // zero delay compares true at once, so trip rises with start
                trip_next = inv_mode ? (acc_next >= thr) : (op_next >= fix_reg);
            end
            else if (trip_reg)
            begin
                trip_next = 1'b0;
                start_next = 1'b0;
                op_next = 19'h00000;
                acc_next = 24'h000000;
            end
            else if (start_reg || rls_reg)
            begin
                trip_next = 1'b0;
                rls_next = 1'b1;
                if (!mode_reg[`SVT_M_DLYREL])
                    start_next = 1'b0;
                if (!mode_reg[`SVT_M_RSTREL])
                begin
                    op_next = 19'h00000;
                    acc_next = 24'h000000;
                end
                else if (mode_reg[`SVT_M_CONT] && tick_5ms)
                begin
                    op_next = op_reg + 19'h00001;
                    acc_next = acc_reg + {8'h00, rate};
                end
                if (tick_5ms)
                    rc_next = rc_reg + 15'h0001;
                if (rc_next >= rel_reg)
                begin
                    rls_next = 1'b0;
                    rc_next = 15'h0000;
                    start_next = 1'b0;
                    op_next = 19'h00000;
                    acc_next = 24'h000000;
                end
            end
        end

        always @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                start_reg <= 1'b0;
                trip_reg <= 1'b0;
                blk_reg <= 1'b0;
                rls_reg <= 1'b0;
                op_reg <= 19'h00000;
                acc_reg <= 24'h000000;
                rc_reg <= 15'h0000;
                ev_reg <= 6'h00;
            end
            else
            begin
                start_reg <= start_next;
                trip_reg <= trip_next;
                blk_reg <= blk_next;
                rls_reg <= rls_next;
                op_reg <= op_next;
                acc_reg <= acc_next;
                rc_reg <= rc_next;
                ev_reg <= ev_next;
            end
        end

        // ---- settings
        always @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                mode_reg <= `SVT_RST_MODE;
                fix_reg <= `SVT_RST_FIX;
                k_reg <= `SVT_RST_K;
                exp_reg <= `SVT_RST_EXP;
                rel_reg <= `SVT_RST_REL;
            end
            else if (reg_wr && cfg_hit)
            begin
                case (reg_addr[1:0])
                    2'h0: mode_reg <= {2'b00, reg_wdata[13:8], 3'b000, reg_wdata[4:0]};
                    2'h1: fix_reg <= reg_wdata[18:0];
                    2'h2:
                    begin
                        k_reg <= reg_wdata[12:0];
                        exp_reg <= reg_wdata[27:16];
                    end
                    default: rel_reg <= reg_wdata[14:0];
                endcase
            end
        end

        // ---- counters and records; a count on the clear cycle survives
        always @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cs_reg <= 16'h0000;
                ct_reg <= 16'h0000;
                cb_reg <= 16'h0000;
                pf_reg <= 16'h0000;
                wp_reg <= 4'h0;
            end
            else
            begin
                cs_reg <= (clr_cnt ? 16'h0000 : cs_reg) + {15'h0000, on_ev[0]};
                ct_reg <= (clr_cnt ? 16'h0000 : ct_reg) + {15'h0000, on_ev[1]};
                cb_reg <= (clr_cnt ? 16'h0000 : cb_reg) + {15'h0000, on_ev[2]};
                if (on_ev[0])
                    pf_reg <= pre200;
                if (|on_ev)
                    wp_reg <= (wp_reg == `SVT_REC_DEPTH - 1) ? 4'h0 : wp_reg + 4'h1;
            end
        end

        always @(posedge clk_sys)
        begin
            if (|on_ev)
            begin
                rec_ts[wp_reg] <= stamp_ms;
                rec_lv[wp_reg] <= {pre20, measured_level};
                rec_id[wp_reg] <= {on_ev[0] ? pre200 : pf_reg, 5'h00, setting_group, 5'h00, on_ev};
                rec_rm[wp_reg] <= {8'h00, rem};
            end
        end

        // ---- read words
        always @*
        begin
            rd_word = 32'h0000_0000;
            if (cfg_hit)
            begin
                case (reg_addr[1:0])
                    2'h0: rd_word = {16'h0000, mode_reg};
                    2'h1: rd_word = {13'h0000, fix_reg};
                    2'h2: rd_word = {4'h0, exp_reg, 3'h0, k_reg};
                    default: rd_word = {17'h00000, rel_reg};
                endcase
            end
            else if (stat_hit)
            begin
                case (reg_addr[1:0])
                    2'h0: rd_word = {20'h00000, wp_reg, 5'h00, blk_reg, trip_reg, start_reg};
                    2'h1: rd_word = {ct_reg, cs_reg};
                    2'h2: rd_word = {16'h0000, cb_reg};
                    default: rd_word = {8'h00, rem};
                endcase
            end
            else if (rec_hit)
            begin
                case (reg_addr[1:0])
                    2'h0: rd_word = rec_ts[reg_addr[5:2]];
                    2'h1: rd_word = rec_lv[reg_addr[5:2]];
                    2'h2: rd_word = rec_id[reg_addr[5:2]];
                    default: rd_word = rec_rm[reg_addr[5:2]];
                endcase
            end
        end

        assign rd_flat[i*32 +: 32] = rd_word;
        assign ev_next_flat[i*6 +: 6] = ev_next;
        assign event_pulse[i*6 +: 6] = ev_reg;
        assign start_out[i] = start_reg;
        assign trip_out[i] = trip_reg;
        assign blocked_out[i] = blk_reg;
    end
endgenerate

// =====================================
// read port and event stamp
always @*
begin
    rd_sel = ctrl_hit ? {29'h0, setting_group} : 32'h0000_0000;
    for (k = 0; k < 4; k = k + 1)
        rd_sel = rd_sel | rd_flat[k*32 +: 32];
end

always @(posedge clk_sys or negedge rst_n)
begin
    if (!rst_n)
    begin
        rdata_reg <= 32'h0000_0000;
        stamp_reg <= 32'h0000_0000;
    end
    else
    begin
        rdata_reg <= reg_rd ? rd_sel : 32'h0000_0000;
        if (|ev_next_flat)
            stamp_reg <= stamp_ms;
    end
end

assign reg_rdata = rdata_reg;
assign event_stamp = stamp_reg;

endmodule // svt_top

// *** testbench/svt_comp_model.sv ***
// pick-up comparator and blocking matrix model
`timescale 1ns/1ps
module svt_comp_model (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // bench commands
    input wire [63:0] lvl_cmd,
    input wire [3:0] blk_cmd,
    // towards the stage block
    output reg [3:0] pickup,
    output reg [3:0] block_in,
    output reg [63:0] ratio_q88
);
    integer i;
    reg [15:0] r;
    always @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            pickup <= 4'h0;
            block_in <= 4'h0;
            ratio_q88 <= 64'h0;
        end
        else
        begin
            block_in <= blk_cmd;
            ratio_q88 <= lvl_cmd;
            for (i = 0; i < 4; i = i + 1)
            begin
                r = lvl_cmd[16*i +: 16];
                // drop-out below 97 percent, so no chatter at the set point
                if (r >= 16'h0100)
                    pickup[i] <= 1'b1;
                else if (r * 100 < 16'h0100 * 97)
                    pickup[i] <= 1'b0;
            end
        end
endmodule // svt_comp_model

// *** testbench/svt_checker.sv ***
// stage 0 port assertions for the timer block
`timescale 1ns/1ps
module svt_checker (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // comparator side
    input wire [3:0] pickup,
    input wire [3:0] block_in,
    // stage outputs
    input wire [3:0] start_out,
    input wire [3:0] trip_out,
    input wire [3:0] blocked_out,
    input wire [23:0] event_pulse,
    input wire [31:0] event_stamp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // =====================================
    // properties
    property p_start; $rose(pickup[0]) && !block_in[0] |=> start_out[0]; endproperty
    property p_cause; $rose(trip_out[0]) |-> $past(pickup[0]) && !$past(block_in[0]); endproperty
    property p_blk; blocked_out[0] == $past(pickup[0] & block_in[0]); endproperty
    property p_with; trip_out[0] |-> start_out[0]; endproperty
    property p_s_on; $rose(start_out[0]) |-> event_pulse[0]; endproperty
    property p_t_on; $rose(trip_out[0]) |-> event_pulse[2]; endproperty
    property p_b_on; $rose(blocked_out[0]) |-> event_pulse[4]; endproperty
    property p_s_off; $fell(start_out[0]) |-> event_pulse[1]; endproperty
    property p_pulse; event_pulse[0] |=> !event_pulse[0]; endproperty
    property p_stamp; !(|event_pulse) |-> $stable(event_stamp); endproperty
    // =====================================
    // assertions
    a_start: assert property (p_start) else $error("start missing");
    a_cause: assert property (p_cause) else $error("trip without pickup");
    a_blk: assert property (p_blk) else $error("blocked level wrong");
    a_with: assert property (p_with) else $error("trip without start");
    a_s_on: assert property (p_s_on) else $error("no start on event");
    a_t_on: assert property (p_t_on) else $error("no trip on event");
    a_b_on: assert property (p_b_on) else $error("no block on event");
    a_s_off: assert property (p_s_off) else $error("no start off event");
    a_pulse: assert property (p_pulse) else $error("event not a pulse");
    a_stamp: assert property (p_stamp) else $error("stamp moved");
    c_trip: cover property ($rose(trip_out[0]));
    c_blk: cover property ($rose(blocked_out[0]));
    c_rel: cover property ($fell(start_out[0]) && !pickup[0]);
endmodule // svt_checker

bind svt_top svt_checker svt_checker_i (.clk_sys(clk_sys), .rst_n(rst_n), .pickup(pickup), .block_in(block_in),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .event_pulse(event_pulse),
    .event_stamp(event_stamp));

// *** testbench/svt_top_tb.sv ***
// self-checking bench for the four-stage timer block
`timescale 1ns/1ps
module svt_top_tb;
    // =====================================
    // stimulus and wiring
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [63:0] lvl_cmd = 64'h0;
    logic [3:0] blk_cmd = 4'h0;
    logic [15:0] measured_level = 16'h1234;
    logic [2:0] setting_group = 3'h5;
    logic [9:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [3:0] pickup, block_in, start_out, trip_out, blocked_out;
    wire [63:0] ratio_q88;
    wire [31:0] reg_rdata, event_stamp;
    wire [23:0] event_pulse;
    int failures = 0;
    int check_count = 0;
    int n;
    int cyc = 0;
    always #25 clk_sys = ~clk_sys;
    // edges since reset release, one ms every 4 of them
    always @(posedge clk_sys)
        if (rst_n)
            cyc <= cyc + 1;
    svt_comp_model svt_comp_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .lvl_cmd(lvl_cmd), .blk_cmd(blk_cmd),
        .pickup(pickup), .block_in(block_in), .ratio_q88(ratio_q88));
    // short ms so one 5 ms tick is 20 cycles
    svt_top #(.MS_CYCLES(4)) svt_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .pickup(pickup), .block_in(block_in),
        .ratio_q88(ratio_q88), .measured_level(measured_level), .setting_group(setting_group),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out), .event_pulse(event_pulse),
        .event_stamp(event_stamp));
    // =====================================
    // shared tasks
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [9:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task rc(input string nm, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(nm, v, exp);
    endtask
    task lvl(input int s, input logic [15:0] r);
        @(posedge clk_sys);
        lvl_cmd[16*s +: 16] <= r;
    endtask
    // k picks start, trip or blocked; bounded so a dead output still ends
    task wt(input int k, input int s, input logic v);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        while ((k == 0 ? start_out[s] : k == 1 ? trip_out[s] : blocked_out[s]) !== v && n < 600);
        chk("wait limit", n < 600, 1);
    endtask
    task report_and_stop;
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // =====================================
    // scenarios
    task t_defaults;
        for (int s = 0; s < 4; s++)
        begin
            rc("mode", 10'h010 + 10'(4 * s), 32'h00003F0C);
            rc("delay", 10'h011 + 10'(4 * s), 32'h00000008);
            rc("dial", 10'h012 + 10'(4 * s), 32'h00640005);
            rc("release", 10'h013 + 10'(4 * s), 32'h0000000C);
        end
        rc("unmapped", 10'h3FF, 32'h00000000);
        rc("group", 10'h000, 32'h00000005);
    endtask
    task t_fixed;
        lvl(0, 16'h0200);
        wt(0, 0, 1'b1);
        chk("start delay", n <= 3, 1);
        wt(1, 0, 1'b1);
        chk("fixed time", n >= 140 && n <= 162, 1);
        rc("counts", 10'h021, 32'h00010001);
        lvl(0, 16'h0080);
        wt(0, 0, 1'b0);
        chk("drop after trip", n <= 3 && trip_out[0] === 1'b0, 1);
        wr(10'h000, 32'h00000001);
        rc("cleared", 10'h021, 32'h00000000);
    endtask
    task t_instant;
        logic [31:0] v;
        int ts;
        wr(10'h015, 32'h00000000);
        lvl(1, 16'h0200);
        wt(0, 1, 1'b1);
        ts = (cyc - 1) / 4;
        chk("instant trip", trip_out[1], 1'b1);
        chk("event stamp", event_stamp, ts);
        rd(10'h242, v);
        chk("record", v & 32'h00000707, 32'h00000503);
        rc("record stamp", 10'h240, ts);
        rc("levels", 10'h241, 32'h12341234);
        rc("slot", 10'h024, 32'h00000103);
        lvl(1, 16'h0080);
        wt(0, 1, 1'b0);
    endtask
    task t_release;
        lvl(0, 16'h0200);
        wt(0, 0, 1'b1);
        repeat (30) @(posedge clk_sys);
        lvl(0, 16'h0080);
        wt(0, 0, 1'b0);
        chk("release hold", n >= 218 && n <= 246, 1);
        chk("no trip", trip_out[0], 1'b0);
        wr(10'h010, 32'h00003F08);
        lvl(0, 16'h0200);
        wt(0, 0, 1'b1);
        lvl(0, 16'h0080);
        wt(0, 0, 1'b0);
        chk("instant release", n <= 3, 1);
    endtask
    task t_inverse;
        wr(10'h01C, 32'h00003F0D);
        lvl(3, 16'h0200);
        wt(0, 3, 1'b1);
        wt(1, 3, 1'b1);
        chk("inverse time", n >= 170 && n <= 230, 1);
        lvl(3, 16'h0080);
    endtask
    task t_block;
        @(posedge clk_sys);
        blk_cmd <= 4'h1;
        lvl(0, 16'h0200);
        wt(2, 0, 1'b1);
        chk("blocked start", start_out[0], 1'b0);
        rc("blocked count", 10'h022, 32'h00000001);
        lvl(0, 16'h0080);
        wt(2, 0, 1'b0);
    endtask
    // stage 2: count on through release, then a drop that restarts the count
    task t_cont;
        wr(10'h018, 32'h0000011C);
        lvl(2, 16'h0200);
        wt(0, 2, 1'b1);
        chk("masked start on", event_pulse[17:12], 6'h01);
        repeat (120) @(posedge clk_sys);
        lvl(2, 16'h0080);
        repeat (100) @(posedge clk_sys);
        #1;
        chk("held in release", start_out[2] === 1'b1 && trip_out[2] === 1'b0, 1);
        lvl(2, 16'h0200);
        wt(1, 2, 1'b1);
        chk("count on in release", n <= 3, 1);
        chk("masked trip on", event_pulse[17:12], 6'h00);
        lvl(2, 16'h0080);
        wt(0, 2, 1'b0);
        wr(10'h018, 32'h00003F04);
        lvl(2, 16'h0200);
        wt(0, 2, 1'b1);
        repeat (120) @(posedge clk_sys);
        lvl(2, 16'h0080);
        repeat (20) @(posedge clk_sys);
        lvl(2, 16'h0200);
        wt(1, 2, 1'b1);
        chk("restart after drop", n >= 140, 1);
        lvl(2, 16'h0080);
        wt(0, 2, 1'b0);
    endtask
    // =====================================
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_defaults;
        t_fixed;
        t_instant;
        t_release;
        t_inverse;
        t_block;
        t_cont;
        report_and_stop;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        report_and_stop;
    end
endmodule // svt_top_tb
